// ---- pkg/gia_cfg.svh ----
`ifndef GIA_CFG_SVH
`define GIA_CFG_SVH
`define GIA_WORD_W 32
`define GIA_CNT_W 64
`define GIA_IMM_W 7
`define GIA_HI_LSB 32
`define GIA_CNT_RST 64'h0000_0000_0000_0000
`define GIA_WORD_RST 32'h0000_0000
`define GIA_REG_ADDR_W 7
`define GIA_ADDR_RST 7'h00
`define GIA_CS_BIT 0
`endif

// ---- pkg/gia_pkg.sv ----
package gia_pkg;
  typedef enum logic [2:0] {
    GIA_OP_NONE = 3'b000,
    GIA_OP_HICYC = 3'b001,
    GIA_OP_ABS = 3'b010,
    GIA_OP_ADD = 3'b011,
    GIA_OP_ADDI = 3'b100,
    GIA_OP_AVG = 3'b101
  } gia_op_t;
endpackage : gia_pkg

// ---- pkg/gia_cnt_if.sv ----
`timescale 1ns/1ns
`include "gia_cfg.svh"
interface gia_cnt_if;
  logic stall;
  logic count_all;
  logic jump_done;
  logic [`GIA_CNT_W-1:0] snapshot;
  modport ctr (input stall, input count_all, input jump_done, output snapshot);
  modport user (output stall, output count_all, output jump_done, input snapshot);
endinterface : gia_cnt_if

// ---- src/gia_cycle_ctr.sv ----
`timescale 1ns/1ns
`include "gia_cfg.svh"
module gia_cycle_ctr (
  input wire logic clk,
  input wire logic rst_n,
  gia_cnt_if.ctr cif
);
  logic [`GIA_CNT_W-1:0] master_q;
  logic [`GIA_CNT_W-1:0] master_d;
  logic [`GIA_CNT_W-1:0] snap_q;
  wire advance = cif.count_all | ~cif.stall;
  assign master_d = advance ? master_q + 64'h0000_0000_0000_0001 : master_q;
  assign cif.snapshot = snap_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      master_q <= `GIA_CNT_RST;
    end else begin
      master_q <= master_d;
    end
  end

  // Reset loads the reset value of the master, so both agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      snap_q <= `GIA_CNT_RST;
    end else if (cif.jump_done) begin
      snap_q <= master_q;
    end
  end

  property p_snap_hold;
    @(posedge clk) disable iff (!rst_n)
    !cif.jump_done |=> $stable(snap_q);
  endproperty
  a_snap_hold: assert property (p_snap_hold) else $error("Snapshot moved without jump");
  property p_snap_load;
    @(posedge clk) disable iff (!rst_n)
    cif.jump_done |=> snap_q == $past(master_q);
  endproperty
  a_snap_load: assert property (p_snap_load) else $error("Snapshot not loaded");
  property p_cnt_step;
    @(posedge clk) disable iff (!rst_n)
    (cif.count_all || !cif.stall) |=> master_q == $past(master_q) + 64'h0000_0000_0000_0001;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("Master did not advance");
  property p_cnt_hold;
    @(posedge clk) disable iff (!rst_n)
    (!cif.count_all && cif.stall) |=> $stable(master_q);
  endproperty
  a_cnt_hold: assert property (p_cnt_hold) else $error("Master advanced on stall");
endmodule : gia_cycle_ctr

// ---- src/gia_alu.sv ----
`timescale 1ns/1ns
`include "gia_cfg.svh"
module gia_alu
  import gia_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic ISSUE_VALID,
  input gia_op_t OPCODE,
  input wire logic [`GIA_IMM_W-1:0] MODIFIER,
  input wire logic GUARD_PRESENT,
  input wire logic [`GIA_WORD_W-1:0] GUARD_VALUE,
  input wire logic [`GIA_WORD_W-1:0] FIRST_SOURCE_REGISTER,
  input wire logic [`GIA_WORD_W-1:0] SECOND_SOURCE_REGISTER,
  input wire logic [`GIA_REG_ADDR_W-1:0] DEST_ADDR,
  input wire logic STALL,
  input wire logic [`GIA_WORD_W-1:0] PROGRAM_STATUS_WORD,
  input wire logic JUMP_DONE,
  output logic WB_EN,
  output logic [`GIA_REG_ADDR_W-1:0] WB_ADDR,
  output logic [`GIA_WORD_W-1:0] WB_DATA
);
  localparam int STALL_CNT_BIT = `GIA_CS_BIT;

  gia_cnt_if cif ();
  assign cif.stall = STALL;
  assign cif.count_all = PROGRAM_STATUS_WORD[STALL_CNT_BIT];
  assign cif.jump_done = JUMP_DONE;

  gia_cycle_ctr u_ctr (
    .clk(MCLK),
    .rst_n(RESET_N),
    .cif(cif)
  );

  // Absolute difference; abs is this with zero first operand
  function automatic logic [`GIA_WORD_W-1:0] absdiff(input logic [`GIA_WORD_W-1:0] a,
                                                     input logic [`GIA_WORD_W-1:0] b);
    logic [`GIA_WORD_W-1:0] d;
    d = a - b;
    // Negation wraps, so 0x8000_0000 maps to itself
    absdiff = d[`GIA_WORD_W-1] ? `GIA_WORD_W'(-d) : d;
  endfunction : absdiff

  wire [`GIA_WORD_W-1:0] src1 = FIRST_SOURCE_REGISTER;
  wire [`GIA_WORD_W-1:0] src2 = SECOND_SOURCE_REGISTER;
  wire [`GIA_WORD_W-1:0] hi_res = cif.snapshot[`GIA_CNT_W-1:`GIA_HI_LSB];
  wire [`GIA_WORD_W-1:0] abs_res = absdiff(`GIA_WORD_RST, src1);
  wire [`GIA_WORD_W-1:0] add_res = src1 + src2;
  wire [`GIA_WORD_W-1:0] addi_res = src1 + {25'h000_0000, MODIFIER};
  wire [`GIA_CNT_W-1:0] avg_sum = {{32{src1[31]}}, src1} + {{32{src2[31]}}, src2}
                                  + 64'h0000_0000_0000_0001;
  wire [`GIA_CNT_W-1:0] avg_shr = {avg_sum[`GIA_CNT_W-1], avg_sum[`GIA_CNT_W-1:1]};
  wire [`GIA_WORD_W-1:0] avg_res = avg_shr[`GIA_WORD_W-1:0];
  wire guard_ok = !GUARD_PRESENT || GUARD_VALUE[0];
  wire op_known = (OPCODE != GIA_OP_NONE) && (OPCODE <= GIA_OP_AVG);
  wire do_write = ISSUE_VALID && op_known && guard_ok;

  // Refused ops still load WB_DATA; only WB_EN gates the write
  logic wb_en_d;
  logic [`GIA_REG_ADDR_W-1:0] wb_addr_d;
  logic [`GIA_WORD_W-1:0] wb_data_d;
  assign wb_en_d = do_write;
  assign wb_addr_d = DEST_ADDR;
  always_comb begin
    case (OPCODE)
      GIA_OP_HICYC: wb_data_d = hi_res;
      GIA_OP_ABS: wb_data_d = abs_res;
      GIA_OP_ADD: wb_data_d = add_res;
      GIA_OP_ADDI: wb_data_d = addi_res;
      GIA_OP_AVG: wb_data_d = avg_res;
      default: wb_data_d = `GIA_WORD_RST;
    endcase
  end

  logic wb_en_q;
  logic [`GIA_REG_ADDR_W-1:0] wb_addr_q;
  logic [`GIA_WORD_W-1:0] wb_data_q;
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      wb_en_q <= 1'b0;
    end else begin
      wb_en_q <= wb_en_d;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      wb_addr_q <= `GIA_ADDR_RST;
    end else begin
      wb_addr_q <= wb_addr_d;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      wb_data_q <= `GIA_WORD_RST;
    end else begin
      wb_data_q <= wb_data_d;
    end
  end

  assign WB_EN = wb_en_q;
  assign WB_ADDR = wb_addr_q;
  assign WB_DATA = wb_data_q;

  // Expected values come from the rules, not from the result wires
  property p_guard;
    @(posedge MCLK) disable iff (!RESET_N)
    (ISSUE_VALID && GUARD_PRESENT && !GUARD_VALUE[0]) |=> !WB_EN;
  endproperty
  a_guard: assert property (p_guard) else $error("Write despite false guard");

  property p_write;
    @(posedge MCLK) disable iff (!RESET_N)
    (ISSUE_VALID && OPCODE != GIA_OP_NONE && OPCODE <= GIA_OP_AVG && (!GUARD_PRESENT || GUARD_VALUE[0]))
    |=> WB_EN;
  endproperty
  a_write: assert property (p_write) else $error("Write missing with true guard");

  property p_refuse;
    @(posedge MCLK) disable iff (!RESET_N)
    (!ISSUE_VALID || OPCODE == GIA_OP_NONE || OPCODE > GIA_OP_AVG) |=> !WB_EN;
  endproperty
  a_refuse: assert property (p_refuse) else $error("Write without a valid issue");

  property p_addr;
    @(posedge MCLK) disable iff (!RESET_N)
    ISSUE_VALID |=> WB_ADDR == $past(DEST_ADDR);
  endproperty
  a_addr: assert property (p_addr) else $error("Write address not echoed");

  property p_hi;
    @(posedge MCLK) disable iff (!RESET_N)
    (ISSUE_VALID && OPCODE == GIA_OP_HICYC && guard_ok) |=>
    WB_EN && WB_DATA == $past(cif.snapshot[`GIA_CNT_W-1:`GIA_HI_LSB]);
  endproperty
  a_hi: assert property (p_hi) else $error("High cycle word wrong");

  property p_hi_pair;
    @(posedge MCLK) disable iff (!RESET_N)
    (ISSUE_VALID && OPCODE == GIA_OP_HICYC && !JUMP_DONE) ##1 (ISSUE_VALID && OPCODE == GIA_OP_HICYC)
    |=> WB_DATA == $past(WB_DATA);
  endproperty
  a_hi_pair: assert property (p_hi_pair) else $error("High word moved without jump");

  property p_abs;
    @(posedge MCLK) disable iff (!RESET_N)
    (ISSUE_VALID && OPCODE == GIA_OP_ABS && guard_ok) |=>
    WB_DATA == ($past(src1[31]) ? 32'h0000_0000 - $past(src1) : $past(src1));
  endproperty
  a_abs: assert property (p_abs) else $error("Absolute value wrong");

  property p_absmin;
    @(posedge MCLK) disable iff (!RESET_N)
    (ISSUE_VALID && OPCODE == GIA_OP_ABS && guard_ok && src1 == 32'h8000_0000) |=>
    WB_DATA == 32'h8000_0000;
  endproperty
  a_absmin: assert property (p_absmin) else $error("Most negative abs wrong");

  property p_absd;
    @(posedge MCLK) disable iff (!RESET_N)
    (ISSUE_VALID && OPCODE == GIA_OP_ABS && guard_ok) |=>
    WB_DATA == (($signed(32'h0000_0000) > $signed($past(src1))) ? 32'h0000_0000 - $past(src1) : $past(src1));
  endproperty
  a_absd: assert property (p_absd) else $error("Abs differs from abs difference");

  property p_add;
    @(posedge MCLK) disable iff (!RESET_N)
    (ISSUE_VALID && OPCODE == GIA_OP_ADD && guard_ok) |=>
    WB_DATA == $past(src1) + $past(src2);
  endproperty
  a_add: assert property (p_add) else $error("Sum wrong");

  property p_addi;
    @(posedge MCLK) disable iff (!RESET_N)
    (ISSUE_VALID && OPCODE == GIA_OP_ADDI && guard_ok) |=>
    WB_DATA == $past(src1) + $past(MODIFIER);
  endproperty
  a_addi: assert property (p_addi) else $error("Immediate sum wrong");

  property p_addi_range;
    @(posedge MCLK) disable iff (!RESET_N)
    (ISSUE_VALID && OPCODE == GIA_OP_ADDI && guard_ok) |=>
    (WB_DATA - $past(src1)) <= 32'h0000_007f;
  endproperty
  a_addi_range: assert property (p_addi_range) else $error("Immediate not taken as unsigned");

  property p_avg;
    @(posedge MCLK) disable iff (!RESET_N)
    (ISSUE_VALID && OPCODE == GIA_OP_AVG && guard_ok) |=>
    $signed(WB_DATA) == 32'($past(($signed(src1) + 64'sd0 + $signed(src2) + 64'sd1) >>> 1));
  endproperty
  a_avg: assert property (p_avg) else $error("Average wrong");

  // No disable here, so the reset cycles themselves are judged
  property p_rst;
    @(posedge MCLK)
    !RESET_N |=> !WB_EN && WB_ADDR == `GIA_ADDR_RST && WB_DATA == `GIA_WORD_RST;
  endproperty
  a_rst: assert property (p_rst) else $error("Outputs not cleared by reset");

  // Main scenarios
  c_guard_false: cover property (@(posedge MCLK)
    ISSUE_VALID && GUARD_PRESENT && !GUARD_VALUE[0]);
  c_hi: cover property (@(posedge MCLK)
    ISSUE_VALID && OPCODE == GIA_OP_HICYC);
  c_absmin: cover property (@(posedge MCLK)
    ISSUE_VALID && OPCODE == GIA_OP_ABS && src1 == 32'h8000_0000);
  c_jump: cover property (@(posedge MCLK)
    JUMP_DONE);
  c_stall_count: cover property (@(posedge MCLK)
    STALL && PROGRAM_STATUS_WORD[STALL_CNT_BIT]);
endmodule : gia_alu

// ---- tb/gia_rf_model.sv ----
`timescale 1ns/1ns
`include "gia_cfg.svh"
module gia_rf_model (
  input wire logic clk,
  input wire logic wb_en,
  input wire logic [`GIA_REG_ADDR_W-1:0] wb_addr,
  input wire logic [`GIA_WORD_W-1:0] wb_data
);
  logic [`GIA_WORD_W-1:0] regs [0:127];
  // Preload so a skipped write never looks like a zero write
  initial begin
    foreach (regs[i]) regs[i] = 32'h5555_5555;
  end
  always @(posedge clk) begin
    if (wb_en) begin
      regs[wb_addr] <= wb_data;
    end
  end
endmodule : gia_rf_model

// ---- tb/gia_alu_bench.sv ----
`timescale 1ns/1ns
`include "gia_cfg.svh"
module gia_alu_bench import gia_pkg::*;;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic issue_valid = 1'b0;
  gia_op_t opcode = GIA_OP_NONE;
  logic [6:0] modifier = 7'h00;
  logic guard_present = 1'b0;
  logic [31:0] guard_value = 32'h0000_0000;
  logic [31:0] src_a = 32'h0000_0000;
  logic [31:0] src_b = 32'h0000_0000;
  logic [6:0] dest_addr = 7'h00;
  logic stall = 1'b0;
  logic [31:0] psw = 32'h0000_0000;
  logic jump_done = 1'b0;
  logic wb_en;
  logic [6:0] wb_addr;
  logic [31:0] wb_data;
  int error_cnt = 0;
  int cmp_count = 0;
  always #50 mclk = ~mclk;
  gia_alu dut (.MCLK(mclk), .RESET_N(reset_n), .ISSUE_VALID(issue_valid), .OPCODE(opcode),
    .MODIFIER(modifier), .GUARD_PRESENT(guard_present), .GUARD_VALUE(guard_value),
    .FIRST_SOURCE_REGISTER(src_a), .SECOND_SOURCE_REGISTER(src_b), .DEST_ADDR(dest_addr),
    .STALL(stall), .PROGRAM_STATUS_WORD(psw), .JUMP_DONE(jump_done), .WB_EN(wb_en),
    .WB_ADDR(wb_addr), .WB_DATA(wb_data));
  gia_rf_model rf (.clk(mclk), .wb_en(wb_en), .wb_addr(wb_addr), .wb_data(wb_data));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Back to back: issue stays high between calls, dropped only by idle
  task automatic op(input gia_op_t oc, input logic [31:0] a, b, input logic [6:0] m,
                    input logic gp, g0, we, input logic [31:0] exp);
    opcode = oc;
    src_a = a;
    src_b = b;
    modifier = m;
    guard_present = gp;
    guard_value = {31'h7fff_ffff, g0};
    dest_addr = dest_addr + 7'h01;
    issue_valid = 1'b1;
    @(posedge mclk);
    #5;
    chk({31'h0, wb_en}, {31'h0, we});
    if (we) begin
      chk(wb_data, exp);
      chk({25'h0, wb_addr}, {25'h0, dest_addr});
    end
  endtask : op
  task automatic idle();
    issue_valid = 1'b0;
    @(posedge mclk);
    #5;
  endtask : idle
  task automatic t_add();
    op(GIA_OP_ADD, 32'h0000_0100, 32'h0000_0f11, 7'h00, 1'b0, 1'b0, 1'b1, 32'h0000_1011);
    op(GIA_OP_ADD, 32'hffff_ff00, 32'hffff_ff9c, 7'h00, 1'b1, 1'b1, 1'b1, 32'hffff_fe9c);
    op(GIA_OP_ADD, 32'hffff_ffff, 32'h0000_0002, 7'h00, 1'b0, 1'b0, 1'b1, 32'h0000_0001);
    op(GIA_OP_ADD, 32'h0000_0100, 32'h0000_0f11, 7'h00, 1'b1, 1'b0, 1'b0, 32'h0000_0000);
    idle();
    chk(rf.regs[dest_addr], 32'h5555_5555);
    $display("add done");
  endtask : t_add
  task automatic t_abs();
    op(GIA_OP_ABS, 32'hffff_ffff, 32'h0, 7'h00, 1'b0, 1'b0, 1'b1, 32'h0000_0001);
    op(GIA_OP_ABS, 32'hffff_fff4, 32'h0, 7'h00, 1'b1, 1'b1, 1'b1, 32'h0000_000c);
    op(GIA_OP_ABS, 32'hffff_fff4, 32'h0, 7'h00, 1'b1, 1'b0, 1'b0, 32'h0000_0000);
    op(GIA_OP_ABS, 32'h8000_0001, 32'h0, 7'h00, 1'b0, 1'b0, 1'b1, 32'h7fff_ffff);
    op(GIA_OP_ABS, 32'h8000_0000, 32'h0, 7'h00, 1'b0, 1'b0, 1'b1, 32'h8000_0000);
    op(GIA_OP_ABS, 32'h7fff_ffff, 32'h0, 7'h00, 1'b0, 1'b0, 1'b1, 32'h7fff_ffff);
    $display("abs done");
  endtask : t_abs
  task automatic t_addi();
    op(GIA_OP_ADDI, 32'h0000_0f11, 32'h0, 7'h7f, 1'b0, 1'b0, 1'b1, 32'h0000_0f90);
    op(GIA_OP_ADDI, 32'hffff_ff9c, 32'h0, 7'h01, 1'b1, 1'b1, 1'b1, 32'hffff_ff9d);
    op(GIA_OP_ADDI, 32'hffff_ff9c, 32'h0, 7'h01, 1'b1, 1'b0, 1'b0, 32'h0000_0000);
    op(GIA_OP_ADDI, 32'hffff_ffff, 32'h0, 7'h00, 1'b0, 1'b0, 1'b1, 32'hffff_ffff);
    op(GIA_OP_ADDI, 32'hffff_fff0, 32'h0, 7'h11, 1'b0, 1'b0, 1'b1, 32'h0000_0001);
    $display("addi done");
  endtask : t_addi
  task automatic t_avg();
    op(GIA_OP_AVG, 32'h0000_0009, 32'h0000_0020, 7'h00, 1'b1, 1'b1, 1'b1, 32'h0000_0015);
    op(GIA_OP_AVG, 32'hffff_fff7, 32'h0000_0002, 7'h00, 1'b0, 1'b0, 1'b1, 32'hffff_fffd);
    op(GIA_OP_AVG, 32'h7fff_ffff, 32'h7fff_ffff, 7'h00, 1'b0, 1'b0, 1'b1, 32'h7fff_ffff);
    op(GIA_OP_AVG, 32'h8000_0000, 32'h8000_0000, 7'h00, 1'b0, 1'b0, 1'b1, 32'h8000_0000);
    op(GIA_OP_AVG, 32'h0000_0010, 32'h0000_0020, 7'h00, 1'b1, 1'b0, 1'b0, 32'h0000_0000);
    $display("avg done");
  endtask : t_avg
  // Upper word cannot move within a short run; stall and jump paths are exercised
  task automatic t_cyc();
    idle();
    stall = 1'b1;
    jump_done = 1'b1;
    idle();
    jump_done = 1'b0;
    psw = 32'h0000_0001;
    op(GIA_OP_HICYC, 32'h0, 32'h0, 7'h00, 1'b0, 1'b0, 1'b1, 32'h0000_0000);
    op(GIA_OP_HICYC, 32'h0, 32'h0, 7'h00, 1'b1, 1'b0, 1'b0, 32'h0000_0000);
    op(GIA_OP_NONE, 32'h0, 32'h0, 7'h00, 1'b0, 1'b0, 1'b0, 32'h0000_0000);
    op(gia_op_t'(3'b110), 32'h0, 32'h0, 7'h00, 1'b0, 1'b0, 1'b0, 32'h0000_0000);
    op(gia_op_t'(3'b111), 32'h0, 32'h0, 7'h00, 1'b0, 1'b0, 1'b0, 32'h0000_0000);
    stall = 1'b0;
    idle();
    $display("cycle read done");
  endtask : t_cyc
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (2000) @(posedge mclk);
    error_cnt++;
    close_out();
  end
  initial begin
    repeat (10) @(posedge mclk);
    #5;
    chk({31'h0, wb_en}, 32'h0);
    reset_n = 1'b1;
    idle();
    t_add();
    t_abs();
    t_addi();
    t_avg();
    t_cyc();
    close_out();
  end
endmodule : gia_alu_bench
